// [logic/bcstq_defines.vh]
`ifndef BCSTQ_DEFINES_VH
`define BCSTQ_DEFINES_VH

// clock and time base
`define BCSTQ_CLK_NS        4
`define BCSTQ_US_NS         1000
`define BCSTQ_CYC_PER_US    (`BCSTQ_US_NS / `BCSTQ_CLK_NS)
`define BCSTQ_FRAME_LSB_US  100

// opcode word layout
`define BCSTQ_OPC_MSB       7
`define BCSTQ_OPC_LSB       0
`define BCSTQ_CC_MSB        12
`define BCSTQ_CC_LSB        8
`define BCSTQ_CC_INV        12

// opcodes handled by this engine slice
`define BCSTQ_OP_LTG        8'h0d
`define BCSTQ_OP_LFR        8'h0e
`define BCSTQ_OP_SFR        8'h0f
`define BCSTQ_OP_PTG        8'h10
`define BCSTQ_OP_PBW        8'h11
`define BCSTQ_OP_PIM        8'h12
`define BCSTQ_OP_PID        8'h13
`define BCSTQ_OP_WTR        8'h14
`define BCSTQ_OP_XFL        8'h15

// execute-and-flip toggles this block address bit
`define BCSTQ_FLIP_MASK     16'h0010

// apb register byte offsets
`define BCSTQ_REG_CTRL      8'h00
`define BCSTQ_REG_START     8'h04
`define BCSTQ_REG_FLAGS     8'h08
`define BCSTQ_REG_STATUS    8'h0c
`define BCSTQ_REG_CONFIG    8'h10
`define BCSTQ_REG_QUEUE     8'h14
`define BCSTQ_REG_FRAME     8'h18
`define BCSTQ_REG_TTAG      8'h1c

// control bits
`define BCSTQ_CTRL_START    0
`define BCSTQ_CTRL_STOP     1

// host-owned general flags
`define BCSTQ_HOST_FLAGS    8'hfc

// reset values
`define BCSTQ_RST_W16       16'h0000
`define BCSTQ_RST_W32       32'h0000_0000

`endif

// [logic/bcstq_exec.v]
`timescale 1ns/10ps
`include "bcstq_defines.vh"
// Operation
// - load timetag op loads time tag counter
// - false condition: skip to next opcode, except execute flip
// - load frame timer op writes frame time
// - start frame timer op starts frame counter
// - push timetag op queues time tag
// - push block status op queues last status
// - push immediate op queues parameter word
// - push indirect op queues word at parameter
// - wait trigger op stalls until trigger rise
// - execute flip op always runs the message
// - true afterwards: write back address xor bit4
// - next pass uses the flipped block address
// - false afterwards: parameter word left unchanged
// - general flags 2-7 shared with host
module bcstq_exec (
    // clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // shared ram port
    output reg         mem_req,
    output reg         mem_we,
    output reg  [15:0] mem_addr,
    output reg  [15:0] mem_wdata,
    input  wire        mem_ack,
    input  wire [15:0] mem_rdata,
    // message processor
    output reg         msg_start,
    output reg  [15:0] msg_addr,
    input  wire        msg_done,
    input  wire [15:0] msg_block_status,
    // condition sources
    input  wire [1:0]  cmp_flags_in,
    input  wire [7:0]  msg_cond_in,
    // trigger pin
    input  wire        external_trigger_in
);
    // engine states
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_FOP   = 4'h1;
    localparam [3:0] ST_FPAR  = 4'h2;
    localparam [3:0] ST_EXEC  = 4'h3;
    localparam [3:0] ST_RIND  = 4'h4;
    localparam [3:0] ST_PUSH  = 4'h5;
    localparam [3:0] ST_WTRG  = 4'h6;
    localparam [3:0] ST_MSG   = 4'h7;
    localparam [3:0] ST_FLIP  = 4'h8;
    localparam [3:0] ST_NEXT  = 4'h9;
    // divider end points, cut to the counter widths on purpose
    localparam integer US_LAST_N  = `BCSTQ_CYC_PER_US - 1;
    localparam integer FRM_LAST_N = `BCSTQ_FRAME_LSB_US - 1;
    localparam [7:0]   US_LAST    = US_LAST_N[7:0];
    localparam [6:0]   FRAME_LAST = FRM_LAST_N[6:0];
    reg  [3:0]  state_ff;      // engine state
    reg  [15:0] ip_ff;         // instruction pointer
    reg  [15:0] op_ff;         // fetched opcode word
    reg  [15:0] par_ff;        // fetched parameter word
    reg  [15:0] start_ff;      // list start address
    reg  [15:0] qbase_ff;      // queue base in ram
    reg  [5:0]  qptr_ff;       // queue write index, wraps at 64
    reg  [15:0] bsw_ff;        // last block status word
    reg  [7:0]  gflags_ff;     // general flags
    reg  [2:0]  ttres_ff;      // time tag resolution select
    reg  [15:0] ttag_ff;       // time tag counter
    reg  [5:0]  ttpre_ff;      // time tag prescaler
    reg  [15:0] ftime_ff;      // frame time register
    reg  [15:0] fcnt_ff;       // frame time counter
    reg         frun_ff;       // frame counter running
    reg  [7:0]  usdiv_ff;      // cycles within a microsecond
    reg  [6:0]  fdiv_ff;       // microseconds within a frame lsb
    reg         stop_ff;       // stop requested by host
    reg         trg_s1_ff;     // trigger sync stage 1
    reg         trg_s2_ff;     // trigger sync stage 2
    reg         trg_d_ff;      // delayed sync trigger
    // apb strobes: access phase completes in the cycle pready is high
    wire        acc_done = psel & penable & pready;
    wire        wr_en    = acc_done & pwrite;
    wire        start_wr = wr_en & (paddr == `BCSTQ_REG_CTRL) & pwdata[`BCSTQ_CTRL_START];
    wire        stop_wr  = wr_en & (paddr == `BCSTQ_REG_CTRL) & pwdata[`BCSTQ_CTRL_STOP];
    wire        flag_wr  = wr_en & (paddr == `BCSTQ_REG_FLAGS);
    // condition evaluation: code 0-7 general flags, 8-15 message conditions
    wire [15:0] cond_vec = {msg_cond_in, gflags_ff[7:2], cmp_flags_in};
    wire [3:0]  cc_sel   = op_ff[`BCSTQ_CC_MSB-1:`BCSTQ_CC_LSB];
    wire        cond     = cond_vec[cc_sel] ^ op_ff[`BCSTQ_CC_INV];
    wire [7:0]  opc      = op_ff[`BCSTQ_OPC_MSB:`BCSTQ_OPC_LSB];
    // time bases; a trigger edge only counts once it is synchronised
    wire        us_tick  = (usdiv_ff == US_LAST);
    wire        fr_tick  = us_tick & (fdiv_ff == FRAME_LAST);
    wire [5:0]  tt_last  = (6'h01 << ttres_ff) - 6'h01;
    wire        tt_tick  = us_tick & (ttpre_ff == tt_last);
    wire        trg_rise = trg_s2_ff & ~trg_d_ff;
    wire [15:0] ip_next  = ip_ff + 16'h0002;
    // trigger synchroniser, first stage read only by the second
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            trg_s1_ff <= 1'b0;
            trg_s2_ff <= 1'b0;
            trg_d_ff  <= 1'b0;
        end else begin
            trg_s1_ff <= external_trigger_in;
            trg_s2_ff <= trg_s1_ff;
            trg_d_ff  <= trg_s2_ff;
        end
    end
    // apb slave: read data latched in setup, answer one cycle later
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata  <= `BCSTQ_RST_W32;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel & ~penable) begin
                prdata <= `BCSTQ_RST_W32;
                case (paddr)
                    `BCSTQ_REG_CTRL:   prdata <= {30'h0, stop_ff, 1'b0};
                    `BCSTQ_REG_START:  prdata <= {16'h0, start_ff};
                    `BCSTQ_REG_FLAGS:  prdata <= {24'h0, gflags_ff[7:2], cmp_flags_in};
                    `BCSTQ_REG_STATUS: prdata <= {ip_ff, 8'h0, state_ff, 2'h0, state_ff == ST_WTRG,
                                                  state_ff != ST_IDLE};
                    `BCSTQ_REG_CONFIG: prdata <= {29'h0, ttres_ff};
                    `BCSTQ_REG_QUEUE:  prdata <= {10'h0, qptr_ff, qbase_ff};
                    `BCSTQ_REG_FRAME:  prdata <= {fcnt_ff, ftime_ff};
                    `BCSTQ_REG_TTAG:   prdata <= {16'h0, ttag_ff};
                    default:           pslverr <= 1'b1; // unmapped: error on access
                endcase
            end
        end
    end
    // host settings and general flags; bits 0-1 belong to compare logic
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            start_ff  <= `BCSTQ_RST_W16;
            qbase_ff  <= `BCSTQ_RST_W16;
            ttres_ff  <= 3'h0;
            gflags_ff <= 8'h00;
            stop_ff   <= 1'b0;
        end else begin
            if (wr_en & (paddr == `BCSTQ_REG_START))
                start_ff <= pwdata[15:0];
            if (wr_en & (paddr == `BCSTQ_REG_QUEUE))
                qbase_ff <= pwdata[15:0];
            if (wr_en & (paddr == `BCSTQ_REG_CONFIG))
                ttres_ff <= pwdata[2:0];
            // low byte sets, high byte clears, both toggle
            if (flag_wr)
                gflags_ff <= ((gflags_ff & ~pwdata[15:8]) | (pwdata[7:0] & ~pwdata[15:8])
                             | (~gflags_ff & pwdata[7:0] & pwdata[15:8])) & `BCSTQ_HOST_FLAGS;
            // stop is taken at the next instruction boundary
            if (stop_wr)
                stop_ff <= 1'b1;
            else if (state_ff == ST_IDLE)
                stop_ff <= 1'b0;
        end
    end
    // timers and sequence engine share one process so loads win over counting
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_ff  <= ST_IDLE;
            ip_ff     <= `BCSTQ_RST_W16;
            op_ff     <= `BCSTQ_RST_W16;
            par_ff    <= `BCSTQ_RST_W16;
            qptr_ff   <= 6'h00;
            bsw_ff    <= `BCSTQ_RST_W16;
            ttag_ff   <= `BCSTQ_RST_W16;
            ttpre_ff  <= 6'h00;
            ftime_ff  <= `BCSTQ_RST_W16;
            fcnt_ff   <= `BCSTQ_RST_W16;
            frun_ff   <= 1'b0;
            usdiv_ff  <= 8'h00;
            fdiv_ff   <= 7'h00;
            mem_req   <= 1'b0;
            mem_we    <= 1'b0;
            mem_addr  <= `BCSTQ_RST_W16;
            mem_wdata <= `BCSTQ_RST_W16;
            msg_start <= 1'b0;
            msg_addr  <= `BCSTQ_RST_W16;
        end else begin
            msg_start <= 1'b0;
            // microsecond and frame-lsb dividers
            usdiv_ff <= us_tick ? 8'h00 : usdiv_ff + 8'h01;
            if (us_tick)
                fdiv_ff <= (fdiv_ff == FRAME_LAST) ? 7'h00 : fdiv_ff + 7'h01;
            if (us_tick)
                ttpre_ff <= tt_tick ? 6'h00 : ttpre_ff + 6'h01;
            if (tt_tick)
                ttag_ff <= ttag_ff + 16'h0001;
            // frame counter counts down to zero and holds
            if (frun_ff & fr_tick) begin
                if (fcnt_ff == `BCSTQ_RST_W16)
                    frun_ff <= 1'b0;
                else
                    fcnt_ff <= fcnt_ff - 16'h0001;
            end
            // any completed message refreshes the block status word
            if (msg_done)
                bsw_ff <= msg_block_status;
            case (state_ff)
                ST_IDLE: begin
                    if (start_wr) begin
                        ip_ff    <= start_ff;
                        mem_addr <= start_ff;
                        mem_req  <= 1'b1;
                        state_ff <= ST_FOP;
                    end
                end
                // opcode word, then the parameter word right behind it
                ST_FOP: begin
                    if (mem_ack) begin
                        op_ff    <= mem_rdata;
                        mem_addr <= ip_ff + 16'h0001;
                        state_ff <= ST_FPAR;
                    end
                end
                ST_FPAR: begin
                    if (mem_ack) begin
                        par_ff   <= mem_rdata;
                        mem_req  <= 1'b0;
                        state_ff <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    state_ff <= ST_NEXT;
                    case (opc)
                        `BCSTQ_OP_LTG:
                            if (cond) begin
                                ttag_ff  <= par_ff;
                                ttpre_ff <= 6'h00;
                            end
                        `BCSTQ_OP_LFR:
                            if (cond)
                                ftime_ff <= par_ff;
                        `BCSTQ_OP_SFR:
                            if (cond) begin
                                fcnt_ff <= ftime_ff;
                                frun_ff <= 1'b1;
                            end
                        `BCSTQ_OP_PTG, `BCSTQ_OP_PBW, `BCSTQ_OP_PIM:
                            if (cond) begin
                                mem_req   <= 1'b1;
                                mem_we    <= 1'b1;
                                mem_addr  <= qbase_ff + {10'h0, qptr_ff};
                                state_ff  <= ST_PUSH;
                                if (opc == `BCSTQ_OP_PTG)
                                    mem_wdata <= ttag_ff;
                                else if (opc == `BCSTQ_OP_PBW)
                                    mem_wdata <= bsw_ff;
                                else
                                    mem_wdata <= par_ff;
                            end
                        `BCSTQ_OP_PID:
                            if (cond) begin
                                mem_req  <= 1'b1;
                                mem_we   <= 1'b0;
                                mem_addr <= par_ff;
                                state_ff <= ST_RIND;
                            end
                        `BCSTQ_OP_WTR:
                            if (cond)
                                state_ff <= ST_WTRG;
                        `BCSTQ_OP_XFL: begin
                            msg_start <= 1'b1;
                            msg_addr  <= par_ff;
                            state_ff  <= ST_MSG;
                        end
                        default: state_ff <= ST_NEXT; // other ops belong elsewhere
                    endcase
                end
                // indirect word comes back, then goes to the queue
                ST_RIND: begin
                    if (mem_ack) begin
                        mem_we    <= 1'b1;
                        mem_wdata <= mem_rdata;
                        mem_addr  <= qbase_ff + {10'h0, qptr_ff};
                        state_ff  <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        mem_we   <= 1'b0;
                        qptr_ff  <= qptr_ff + 6'h01;
                        state_ff <= ST_NEXT;
                    end
                end
                // stop request also releases a stalled trigger wait
                ST_WTRG:
                    if (trg_rise | stop_ff)
                        state_ff <= ST_NEXT;
                // condition is sampled only once the message is done
                ST_MSG: begin
                    if (msg_done) begin
                        state_ff <= ST_NEXT;
                        if (cond) begin
                            mem_req   <= 1'b1;
                            mem_we    <= 1'b1;
                            mem_addr  <= ip_ff + 16'h0001;
                            mem_wdata <= par_ff ^ `BCSTQ_FLIP_MASK;
                            state_ff  <= ST_FLIP;
                        end
                    end
                end
                // fetch of the next opcode waits for the write-back ack
                ST_FLIP: begin
                    if (mem_ack) begin
                        mem_req  <= 1'b0;
                        mem_we   <= 1'b0;
                        state_ff <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (stop_ff)
                        state_ff <= ST_IDLE;
                    else begin
                        ip_ff    <= ip_next;
                        mem_addr <= ip_next;
                        mem_req  <= 1'b1;
                        state_ff <= ST_FOP;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end
endmodule // bcstq_exec

// [testbench/bcstq_exec_properties.sv]
`timescale 1ns/10ps
// port-level checks on the engine slice
module bcstq_exec_props (
    // clock and reset
    input wire logic        mclk,
    input wire logic        sys_rst,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // shared ram
    input wire logic        mem_req,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        mem_ack,
    input wire logic [15:0] mem_rdata,
    // message processor
    input wire logic        msg_start,
    input wire logic [15:0] msg_addr,
    input wire logic        msg_done
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [15:0] rd_addr_ff;   // address of the last word read
    logic [15:0] rd_data_ff;   // last word read
    logic [15:0] xq_pa_ff;     // where the flip message's parameter lives
    logic        flip_wait_ff; // message done, first access not yet acked
    // track the parameter fetch so the write-back target is known
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_addr_ff   <= 16'h0000;
            rd_data_ff   <= 16'h0000;
            xq_pa_ff     <= 16'h0000;
            flip_wait_ff <= 1'b0;
        end else begin
            if (mem_ack && !mem_we) begin
                rd_addr_ff <= mem_addr;
                rd_data_ff <= mem_rdata;
            end
            if (msg_start)
                xq_pa_ff <= rd_addr_ff;
            if (msg_done)
                flip_wait_ff <= 1'b1;
            else if (mem_ack)
                flip_wait_ff <= 1'b0;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_after_msg;
        flip_wait_ff && mem_req;
    endsequence
    chk_ready_setup: assert property (s_setup |=> pready)
        else $error("no ready after setup");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("ready without setup");
    chk_slverr_map: assert property (pready |-> pslverr == (paddr > 8'h1c || paddr[1:0] != 2'b00))
        else $error("slave error does not match map");
    chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
        && $stable(mem_wdata)) else $error("memory request changed before ack");
    chk_msg_quiet: assert property (msg_start |=> (!msg_start && !mem_req) [*4])
        else $error("engine moved on during message");
    chk_msg_param: assert property (msg_start |-> msg_addr == rd_data_ff)
        else $error("message address is not the parameter");
    chk_flip_write: assert property (s_after_msg ##0 mem_we |-> mem_addr == xq_pa_ff
        && mem_wdata == (msg_addr ^ 16'h0010)) else $error("bad flip write-back");
    chk_skip_fetch: assert property (s_after_msg ##0 !mem_we |-> mem_addr == xq_pa_ff + 16'h0001)
        else $error("bad fetch after message");
endmodule // bcstq_exec_props
bind bcstq_exec bcstq_exec_props u_props (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .msg_start(msg_start), .msg_addr(msg_addr), .msg_done(msg_done));

// [testbench/bcstq_partner.sv]
`timescale 1ns/10ps
// shared ram and message processor seen from the engine's far side
module bcstq_partner (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    // shared ram port
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic             mem_ack,
    output logic      [15:0] mem_rdata,
    // message processor
    input  wire logic        msg_start,
    input  wire logic [15:0] msg_addr,
    output logic             msg_done,
    output logic      [15:0] msg_block_status
);
    logic [15:0] ram [0:4095];   // 4k word image, preloaded by the host side
    integer      seed = 32'hf6e8c7a9;
    integer      wait_n;         // idle cycles left before the ack
    integer      msg_n;          // cycles left in the running message
    // each access is answered after 1..3 cycles; one ack ends exactly one access
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            mem_ack   <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_n    <= -1;
        end else if (mem_ack || !mem_req) begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata; // stale data never looks valid
            wait_n    <= -1;
        end else if (wait_n < 0) begin
            wait_n <= $unsigned($random(seed)) % 3;
        end else if (wait_n == 0) begin
            mem_ack <= 1'b1;
            if (mem_we)
                ram[mem_addr[11:0]] <= mem_wdata;
            else
                mem_rdata <= ram[mem_addr[11:0]];
        end else begin
            wait_n <= wait_n - 1;
        end
    end
    // a message lasts 4..11 cycles; its status is a5 over the block address low byte
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            msg_done         <= 1'b0;
            msg_n            <= 0;
            msg_block_status <= 16'h0000;
        end else begin
            msg_done <= (msg_n == 1);
            if (msg_start) begin
                msg_n            <= 4 + $unsigned($random(seed)) % 8;
                msg_block_status <= {8'ha5, msg_addr[7:0]};
            end else if (msg_n > 0) begin
                msg_n <= msg_n - 1;
            end
        end
    end
endmodule // bcstq_partner

// [testbench/tb_bc_sequence_timer_queue_ops.sv]
`timescale 1ns/10ps
// engine slice bench: host over apb, ram and message processor in the partner
module tb_bc_sequence_timer_queue_ops;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, mem_req, mem_we, mem_ack, msg_start, msg_done;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, msg_addr, msg_block_status;
    logic [1:0]  cmp_flags_in = 2'b00;
    logic [7:0]  msg_cond_in = 8'h80;        // code 15 always true
    logic        external_trigger_in = 1'b0;
    integer      seed = 32'hf6e8c7a9;
    integer      err_total = 0, check_count = 0, cycles = 0, i;
    logic [31:0] rd;                         // last apb read data
    logic        rd_err;                     // last apb error flag
    logic [15:0] exp_q[$], exp_msg[$];       // expected queue words, message order
    logic [15:0] t_val, f_val, p_val, p2_val, ind_val;

    always #2 mclk = ~mclk;

    bcstq_exec u_dut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .msg_start(msg_start), .msg_addr(msg_addr), .msg_done(msg_done),
        .msg_block_status(msg_block_status), .cmp_flags_in(cmp_flags_in), .msg_cond_in(msg_cond_in),
        .external_trigger_in(external_trigger_in));
    bcstq_partner u_mem (.mclk(mclk), .sys_rst(sys_rst), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .msg_start(msg_start), .msg_addr(msg_addr), .msg_done(msg_done), .msg_block_status(msg_block_status));

    task chk(input logic [31:0] exp, input logic [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t exp %h got %h", $time, exp, got);
        end
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        rd_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // poll one status bit under a bounded count
    task wait_st(input integer b, input logic v);
        integer n;
        n = 0;
        do begin
            apb(1'b0, 8'h0c, 32'h0);
            n = n + 1;
        end while (rd[b] !== v && n < 500);
        chk(32'(v), 32'(rd[b]));
    endtask
    task put(input logic [11:0] a, input logic [15:0] op, input logic [15:0] prm);
        u_mem.ram[a] = op;
        u_mem.ram[a + 12'h001] = prm;
    endtask
    task run_to_wait(input logic [15:0] a);
        apb(1'b1, 8'h04, 32'(a));
        apb(1'b1, 8'h00, 32'h1);
        wait_st(1, 1'b1);
    endtask
    task halt;
        apb(1'b1, 8'h00, 32'h2);
        wait_st(0, 1'b0);
    endtask

    // every message start is checked against the expected block order; hang guard
    always @(posedge mclk) begin
        cycles = cycles + 1;
        if (msg_start === 1'b1)
            chk(32'(exp_msg.pop_front()), 32'(msg_addr));
        if (cycles > 40000) begin
            err_total = err_total + 1;
            wrap_up;
        end
    end

    initial begin
        t_val = 16'($random(seed));
        f_val = 16'($random(seed));
        p_val = 16'($random(seed));
        p2_val = 16'($random(seed));
        ind_val = 16'($random(seed));
        u_mem.ram[12'h300] = ind_val;
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        cmp_flags_in <= 2'($random(seed));
        // host flags: set all, clear 2-3, toggle 7 (only 2..7 may move)
        apb(1'b1, 8'h08, 32'h0000_00ff);
        apb(1'b1, 8'h08, 32'h0000_0c00);
        apb(1'b1, 8'h08, 32'h0000_8080);
        apb(1'b0, 8'h08, 32'h0);
        chk(32'({6'h1c, cmp_flags_in}), 32'(rd[7:0]));
        apb(1'b0, 8'h20, 32'h0);
        chk(32'h1, 32'(rd_err));
        apb(1'b1, 8'h14, 32'h0000_0800);
        apb(1'b1, 8'h10, 32'h0000_0005);     // tag ticks every 32 us: none between load and push
        // same flip line run twice: block address alternates
        put(12'h180, 16'h0f15, 16'h0200);
        put(12'h182, 16'h0f14, 16'h0000);
        exp_msg = {16'h0200, 16'h0210, 16'h0220};
        run_to_wait(16'h0180);
        chk(32'h0210, 32'(u_mem.ram[12'h181]));
        halt;
        run_to_wait(16'h0180);
        chk(32'h0200, 32'(u_mem.ram[12'h181]));
        halt;
        put(12'h100, 16'h0f0d, t_val);
        put(12'h102, 16'h0f0e, f_val);
        put(12'h104, 16'h0f0f, 16'hffff);
        put(12'h106, 16'h0f10, 16'hffff);
        put(12'h108, 16'h0f11, 16'hffff);
        put(12'h10a, 16'h0612, p_val);
        put(12'h10c, 16'h0f13, 16'h0300);
        put(12'h10e, 16'h0712, 16'h9999);
        put(12'h110, 16'h1f15, 16'h0220);
        put(12'h112, 16'h0f14, 16'h0000);
        put(12'h114, 16'h0f12, p2_val);
        put(12'h116, 16'h1f14, 16'h0000);
        put(12'h118, 16'h0f14, 16'h0000);
        exp_q = {t_val, 16'ha510, p_val, ind_val, p2_val};
        run_to_wait(16'h0100);
        apb(1'b0, 8'h18, 32'h0);
        chk({f_val, f_val}, rd);
        repeat (40) @(posedge mclk);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'h4, 32'(rd[21:16]));
        external_trigger_in <= 1'b1;
        repeat (8) @(posedge mclk);
        external_trigger_in <= 1'b0;
        wait_st(1, 1'b1);
        apb(1'b0, 8'h14, 32'h0);
        chk(32'h5, 32'(rd[21:16]));
        halt;
        chk(32'h0220, 32'(u_mem.ram[12'h111]));
        for (i = 0; i < 5; i = i + 1)
            chk(32'(exp_q[i]), 32'(u_mem.ram[12'h800 + i]));
        chk(32'h0, 32'(exp_msg.size()));
        wrap_up;
    end
endmodule // tb_bc_sequence_timer_queue_ops
